/* shared/rsrb_params.svh */
`ifndef RSRB_PARAMS_SVH
`define RSRB_PARAMS_SVH

// ==========================================================================
// Register offsets on the plain register port.
`define RSRB_OFS_REG_CTRL     8'h2a
`define RSRB_OFS_REG_TIMER    8'h2b
`define RSRB_OFS_STRENGTH     8'h2c
`define RSRB_OFS_GAIN_CUT     8'h2d
`define RSRB_OFS_COMMAND      8'h3f

// ==========================================================================
// Field positions.
`define RSRB_CTRL_MODE_BIT    7
`define RSRB_CTRL_EXT_HI      6
`define RSRB_CTRL_EXT_LO      3
`define RSRB_CMD_DEFAULT_BIT  0
`define RSRB_CMD_CLR_STR_BIT  1

// ==========================================================================
// Reset values and code limits.
`define RSRB_BYTE_ZERO        8'h00
`define RSRB_NIB_ZERO         4'h0
`define RSRB_CODE_MAX         4'hf
`define RSRB_CODE_MIN_USED    4'h5

`endif

/* shared/rsrb_pkg.sv */
package rsrb_pkg;

  // ========================================================================
  // Types shared by the readback bank.

  // Running flags of the three protocol timers.
  typedef struct packed {
    logic gpt_run;
    logic nrt_run;
    logic mrt_run;
  } rsrb_timer_s;

  // Contributions to the second-stage gain cut of one channel.
  typedef struct packed {
    logic [3:0] cfg_cut;
    logic [3:0] squelch_cut;
    logic [3:0] agc_cut;
  } rsrb_gain_src_s;

  // One strength measurement from a demodulation channel.
  typedef struct packed {
    logic       valid;
    logic [3:0] code;
  } rsrb_strength_s;

  // One-hot clear kind for a cycle: none, set default or strength clear.
  typedef enum logic [2:0] {
    RSRB_ST_RUN     = 3'b001,
    RSRB_ST_DEFAULT = 3'b010,
    RSRB_ST_CLEAR   = 3'b100
  } rsrb_clr_e;

endpackage

/* src/rsrb_gain_sum.sv */
`timescale 1ns/1ps
`include "rsrb_params.svh"

// ==========================================================================
// Total second-stage gain cut of one channel, saturating at the top code.
module rsrb_gain_sum
  import rsrb_pkg::*;
(
  // Contributions.
  input  rsrb_gain_src_s src,
  // Combined cut, bit 3 most significant.
  output logic [3:0]     total
);

  logic [5:0] sum;   // Wide enough for three 4-bit terms.

  // Saturation keeps a large squelch from wrapping round to a small cut.
  always_comb begin
    sum = {2'b00, src.cfg_cut} + {2'b00, src.squelch_cut}
        + {2'b00, src.agc_cut};
    if (sum > {2'b00, `RSRB_CODE_MAX}) begin
      total = `RSRB_CODE_MAX;
    end else begin
      total = sum[3:0];
    end
  end

endmodule

/* src/rsrb_peak_hold.sv */
`timescale 1ns/1ps
`include "rsrb_params.svh"

// ==========================================================================
// Peak hold of one channel's signal-strength code.
module rsrb_peak_hold
  import rsrb_pkg::*;
#(
  parameter int W = 4
) (
  // Clock, reset and freeze.
  input  wire logic         clk,
  input  wire logic         rst_sync_n,
  input  wire logic         clk_en,
  // Measurement and clear.
  input  wire logic         sample_valid,
  input  wire logic [W-1:0] sample_code,
  input  wire logic         clear,
  // Held peak.
  output logic      [W-1:0] peak
);

  logic [W-1:0] peak_q;   // Largest code seen since the last clear.

  // A clear wins over a sample in the same cycle: the new message or the
  // command defines a fresh start, and the sample belongs to the old one.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      peak_q <= '0;
    end else if (clk_en) begin
      if (clear) begin
        peak_q <= '0;
      end else if (sample_valid && (sample_code > peak_q)) begin
        peak_q <= sample_code;
      end
    end
  end

  assign peak = peak_q;

endmodule

/* src/rsrb_top.sv */
// Behaviour
// - Regulator register bits 7:4 show voltage code
// - Code 1111 highest, 0101 lowest used
// - Bit 2 high while general timer counts
// - Bit 1 high while no-response timer active
// - Bit 0 high while mask-receive timer active
// - Strength bits 7:4 hold AM peak
// - Strength bits 3:0 hold PM peak
// - Peaks clear on message start, clear command
// - Strength code rises monotonically with input
// - Channel select bit picks strength for logic
// - Gain bits 7:4 total AM cut
// - Gain bits 3:0 total PM cut
// - Strength, gain zero at power-up, set-default (gain byte zero for one cycle only, then the live cut)
// - Mode bit picks adjusted or external code
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "rsrb_params.svh"

// ==========================================================================
// Receiver status readback bank.
module rsrb_top
  import rsrb_pkg::*;
(
  // Clock, reset and freeze.
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Register port.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Regulator adjustment result.
  input  wire logic [3:0] adj_code,
  // Protocol timers.
  input  rsrb_timer_s     timers,
  // Demodulation channel measurements.
  input  rsrb_strength_s  am_meas,
  input  rsrb_strength_s  pm_meas,
  input  wire logic       chan_pm_sel,
  // Gain cut contributions.
  input  rsrb_gain_src_s  am_gain_src,
  input  rsrb_gain_src_s  pm_gain_src,
  // Message and command events.
  input  wire logic       msg_start,
  input  wire logic       clr_strength_cmd,
  input  wire logic       set_default_cmd,
  // Status towards the receiver logic.
  output logic      [3:0] strength_for_logic,
  output logic      [3:0] reg_code,
  output logic            reg_code_used
);

  // ========================================================================
  // Reset synchroniser.

  logic rst_meta_q;   // First stage, read only by the second.
  logic rst_sync_q;   // Released reset used everywhere else.

  // Assert at once, release after two edges so no flop sees a runt edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ========================================================================
  // Command decode.

  logic       wr_ctrl;       // Write to the regulator control register.
  logic       wr_cmd;        // Write to the command register.
  logic       sw_default;    // Software set-default pulse.
  logic       sw_clr_str;    // Software clear-strength pulse.
  logic       do_default;    // Set default from either source.
  logic       do_clr_peak;   // Anything that empties the peak holders.
  rsrb_clr_e  clr_state;     // Which clear applies this cycle.

  // Only the control and command offsets accept writes; the three
  // readback offsets take no write path at all.
  always_comb begin
    wr_ctrl = reg_wr && (reg_addr == `RSRB_OFS_REG_CTRL);
    wr_cmd  = reg_wr && (reg_addr == `RSRB_OFS_COMMAND);
    sw_default = wr_cmd && reg_wdata[`RSRB_CMD_DEFAULT_BIT];
    sw_clr_str = wr_cmd && reg_wdata[`RSRB_CMD_CLR_STR_BIT];
    do_default = set_default_cmd || sw_default;
  end

  // Set default outranks the strength clear since it clears more.
  always_comb begin
    if (do_default) begin
      clr_state = RSRB_ST_DEFAULT;
    end else if (msg_start || clr_strength_cmd || sw_clr_str) begin
      clr_state = RSRB_ST_CLEAR;
    end else begin
      clr_state = RSRB_ST_RUN;
    end
  end

  // Peaks empty on either clear kind.
  always_comb begin
    case (clr_state)
      RSRB_ST_DEFAULT: do_clr_peak = 1'b1;
      RSRB_ST_CLEAR:   do_clr_peak = 1'b1;
      RSRB_ST_RUN:     do_clr_peak = 1'b0;
      default:         do_clr_peak = 1'b1;
    endcase
  end

  // ========================================================================
  // Regulator control register.

  logic       reg_mode_q;   // 0: adjustment result, 1: external code.
  logic [3:0] ext_code_q;   // Externally defined regulator code.

  // Software steers the regulator code source here; set default
  // returns the bank to adjustment mode.
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      reg_mode_q <= 1'b0;
      ext_code_q <= `RSRB_NIB_ZERO;
    end else if (clk_en) begin
      if (do_default) begin
        reg_mode_q <= 1'b0;
        ext_code_q <= `RSRB_NIB_ZERO;
      end else if (wr_ctrl) begin
        reg_mode_q <= reg_wdata[`RSRB_CTRL_MODE_BIT];
        ext_code_q <= reg_wdata[`RSRB_CTRL_EXT_HI:`RSRB_CTRL_EXT_LO];
      end
    end
  end

  // ========================================================================
  // Regulator and timer readback.

  logic [3:0]  reg_code_q;   // Regulator code currently in effect.
  rsrb_timer_s timer_q;      // Registered timer running flags.

  // The code in effect follows the selected source every cycle.
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      reg_code_q <= `RSRB_NIB_ZERO;
    end else if (clk_en) begin
      if (reg_mode_q) begin
        reg_code_q <= ext_code_q;
      end else begin
        reg_code_q <= adj_code;
      end
    end
  end

  // Timer flags are level copies; they lag the timers by one cycle.
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      timer_q <= '0;
    end else if (clk_en) begin
      timer_q <= timers;
    end
  end

  // Codes from 0101 up are the used levels, 1111 the highest; anything
  // below is flagged so the regulator logic can refuse it.
  always_comb begin
    reg_code      = reg_code_q;
    reg_code_used = (reg_code_q >= `RSRB_CODE_MIN_USED);
  end

  // ========================================================================
  // Signal-strength peaks.

  logic [3:0] am_peak;   // AM channel peak.
  logic [3:0] pm_peak;   // PM channel peak.

  // Codes are compared as unsigned numbers, which is only right because
  // the code grows monotonically with input level.
  rsrb_peak_hold #(
    .W (4)
  ) u_am_peak (
    .clk          (sys_clk),
    .rst_sync_n   (rst_sync_q),
    .clk_en       (clk_en),
    .sample_valid (am_meas.valid),
    .sample_code  (am_meas.code),
    .clear        (do_clr_peak),
    .peak         (am_peak)
  );

  rsrb_peak_hold #(
    .W (4)
  ) u_pm_peak (
    .clk          (sys_clk),
    .rst_sync_n   (rst_sync_q),
    .clk_en       (clk_en),
    .sample_valid (pm_meas.valid),
    .sample_code  (pm_meas.code),
    .clear        (do_clr_peak),
    .peak         (pm_peak)
  );

  logic [3:0] sel_strength_q;   // Strength handed to internal logic.

  // The channel select picks which peak the receiver logic uses.
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sel_strength_q <= `RSRB_NIB_ZERO;
    end else if (clk_en) begin
      if (chan_pm_sel) begin
        sel_strength_q <= pm_peak;
      end else begin
        sel_strength_q <= am_peak;
      end
    end
  end

  assign strength_for_logic = sel_strength_q;

  // ========================================================================
  // Gain cut readback.

  logic [3:0] am_cut;     // Combined AM cut.
  logic [3:0] pm_cut;     // Combined PM cut.
  logic [7:0] gain_q;     // Registered gain cut byte.

  rsrb_gain_sum u_am_cut (
    .src   (am_gain_src),
    .total (am_cut)
  );

  rsrb_gain_sum u_pm_cut (
    .src   (pm_gain_src),
    .total (pm_cut)
  );

  // Set default holds the byte at zero for its cycle; afterwards the
  // live cut reappears, since the cut is state of the AGC, not of us.
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      gain_q <= `RSRB_BYTE_ZERO;
    end else if (clk_en) begin
      if (do_default) begin
        gain_q <= `RSRB_BYTE_ZERO;
      end else begin
        gain_q <= {am_cut, pm_cut};
      end
    end
  end

  // ========================================================================
  // Read path.

  logic [7:0] rd_mux;      // Byte selected by the read address.
  logic [7:0] rdata_q;     // Read data, valid the cycle after the strobe.

  // Unmapped offsets and the write-only command register read as zero.
  always_comb begin
    case (reg_addr)
      `RSRB_OFS_REG_CTRL: begin
        rd_mux = {reg_mode_q, ext_code_q, 3'b000};
      end
      `RSRB_OFS_REG_TIMER: begin
        rd_mux = {reg_code_q, 1'b0, timer_q.gpt_run,
                  timer_q.nrt_run, timer_q.mrt_run};
      end
      `RSRB_OFS_STRENGTH: begin
        rd_mux = {am_peak, pm_peak};
      end
      `RSRB_OFS_GAIN_CUT: begin
        rd_mux = gain_q;
      end
      default: begin
        rd_mux = `RSRB_BYTE_ZERO;
      end
    endcase
  end

  // Read data is held until the next read, but only the cycle after the
  // strobe is promised to the master.
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= `RSRB_BYTE_ZERO;
    end else if (clk_en) begin
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata = rdata_q;

endmodule

/* tb/receiver_status_readback_test.sv */
`timescale 1ns/1ps

// ==========================================================================
// Self-checking bench driving the register port and status sources.
module receiver_status_readback_test
  import rsrb_pkg::*;
;
  logic           sys_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           clk_en = 1'b1;
  logic [7:0]     reg_addr = 8'h00;
  logic [7:0]     reg_wdata = 8'h00;
  logic           reg_wr = 1'b0;
  logic           reg_rd = 1'b0;
  logic [7:0]     reg_rdata;
  logic [3:0]     adj_code = 4'h0;
  rsrb_timer_s    timers = '0;
  rsrb_strength_s am_meas = '0;
  rsrb_strength_s pm_meas = '0;
  logic           chan_pm_sel = 1'b0;
  rsrb_gain_src_s am_gain_src = '0;
  rsrb_gain_src_s pm_gain_src = '0;
  logic           msg_start = 1'b0;
  logic           clr_strength_cmd = 1'b0;
  logic           set_default_cmd = 1'b0;
  logic [3:0]     strength_for_logic;
  logic [3:0]     reg_code;
  logic           reg_code_used;
  int             num_errors = 0;
  int             tests_run = 0;
  int             cycles = 0;
  int             i;
  // External codes: top, lowest used and first unused value.
  logic [3:0]     codes[3] = '{4'hf, 4'h5, 4'h4};
  // Read-only contents expected to survive writes of all ones.
  logic [7:0]     ro_exp[3] = '{8'h90, 8'h7a, 8'hcf};

  always #5 sys_clk = ~sys_clk;

  rsrb_top u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adj_code(adj_code),
    .timers(timers), .am_meas(am_meas), .pm_meas(pm_meas),
    .chan_pm_sel(chan_pm_sel), .am_gain_src(am_gain_src),
    .pm_gain_src(pm_gain_src), .msg_start(msg_start),
    .clr_strength_cmd(clr_strength_cmd),
    .set_default_cmd(set_default_cmd),
    .strength_for_logic(strength_for_logic), .reg_code(reg_code),
    .reg_code_used(reg_code_used)
  );

  // Byte compare; narrower results are zero-extended by the caller.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read strobe; data are looked at in the following cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // One strength measurement on both channels.
  task automatic sample(input logic [3:0] a, input logic [3:0] p);
    @(posedge sys_clk);
    am_meas <= {1'b1, a};
    pm_meas <= {1'b1, p};
    @(posedge sys_clk);
    am_meas <= '0;
    pm_meas <= '0;
  endtask

  task automatic print_verdict;
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A hang counts as a mismatch; the run needs about 130 cycles.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict;
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(8'h2c, 8'h00);
    rd(8'h2d, 8'h00);
    adj_code <= 4'h9;
    for (i = 0; i < 8; i++) begin
      timers <= i[2:0];
      rd(8'h2b, {4'h9, 1'b0, i[2:0]});
    end
    timers <= '0;
    for (i = 0; i < 3; i++) begin
      wr(8'h2a, {1'b1, codes[i], 3'b000});
      rd(8'h2b, {codes[i], 4'h0});
      chk({7'h0, reg_code_used}, {7'h0, codes[i] >= 4'h5});
    end
    wr(8'h2a, 8'h00);
    rd(8'h2b, 8'h90);
    sample(4'h3, 4'h2);
    sample(4'h7, 4'ha);
    sample(4'h5, 4'h1);
    rd(8'h2c, 8'h7a);
    chk({4'h0, strength_for_logic}, 8'h07);
    chan_pm_sel <= 1'b1;
    rd(8'h2c, 8'h7a);
    chk({4'h0, strength_for_logic}, 8'h0a);
    // A sample while frozen must leave the peaks alone.
    clk_en <= 1'b0;
    sample(4'hf, 4'hf);
    clk_en <= 1'b1;
    rd(8'h2c, 8'h7a);
    am_gain_src <= {4'h3, 4'h4, 4'h5};
    pm_gain_src <= {4'h8, 4'h7, 4'h6};
    rd(8'h2d, 8'hcf);
    for (i = 0; i < 3; i++) wr(8'h2b + i[7:0], 8'hff);
    for (i = 0; i < 3; i++) rd(8'h2b + i[7:0], ro_exp[i]);
    rd(8'h10, 8'h00);
    rd(8'h3f, 8'h00);
    // Message start, clear pin and clear command; clear beats a sample.
    for (i = 0; i < 3; i++) begin
      sample(4'hd, 4'he);
      rd(8'h2c, 8'hde);
      if (i == 2) begin
        wr(8'h3f, 8'h02);
      end else begin
        @(posedge sys_clk);
        msg_start <= (i == 0);
        clr_strength_cmd <= (i == 1);
        am_meas <= {1'b1, 4'hc};
        @(posedge sys_clk);
        msg_start <= 1'b0;
        clr_strength_cmd <= 1'b0;
        am_meas <= '0;
      end
      rd(8'h2c, 8'h00);
    end
    // Set default by pin, then by command.
    for (i = 0; i < 2; i++) begin
      sample(4'hd, 4'he);
      wr(8'h2a, 8'ha8);
      if (i == 1) begin
        wr(8'h3f, 8'h01);
      end else begin
        @(posedge sys_clk);
        set_default_cmd <= 1'b1;
        reg_addr <= 8'h2d;
        @(posedge sys_clk);
        set_default_cmd <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, 8'h00);
      end
      rd(8'h2d, 8'hcf);
      rd(8'h2c, 8'h00);
      rd(8'h2a, 8'h00);
    end
    print_verdict;
  end
endmodule

/* tb/rsrb_top_chk.sv */
`timescale 1ns/1ps

// ==========================================================================
// Port-level checker for the readback bank.
module rsrb_top_chk
  import rsrb_pkg::*;
(
  // Clock, reset and freeze.
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Status sources and events.
  input rsrb_timer_s     timers,
  input rsrb_strength_s  am_meas,
  input rsrb_strength_s  pm_meas,
  input rsrb_gain_src_s  am_gain_src,
  input rsrb_gain_src_s  pm_gain_src,
  input wire logic       msg_start,
  input wire logic       clr_strength_cmd,
  input wire logic       set_default_cmd,
  // Status outputs.
  input wire logic [3:0] strength_for_logic,
  input wire logic [3:0] reg_code,
  input wire logic       reg_code_used
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // A read is only taken while the clock enable is high.
  wire rd_ok = reg_rd && clk_en;

  // Saturating cut sum, kept apart from the design's own adder.
  function automatic logic [3:0] sat(rsrb_gain_src_s s);
    logic [5:0] t;
    t = 6'(s.cfg_cut) + 6'(s.squelch_cut) + 6'(s.agc_cut);
    return (t > 6'h0f) ? 4'hf : t[3:0];
  endfunction

  // A clear, one quiet cycle, then a strength read.
  sequence s_clear;
    clk_en && (msg_start || clr_strength_cmd) ##1
    clk_en && !am_meas.valid && !pm_meas.valid ##1
    rd_ok && reg_addr == 8'h2c;
  endsequence
  // An external-mode control write followed by a quiet cycle.
  sequence s_ext_wr;
    clk_en && reg_wr && reg_addr == 8'h2a && reg_wdata[7] ##1
    clk_en && !set_default_cmd && !reg_wr;
  endsequence

  property p_reg_rd;
    rd_ok && reg_addr == 8'h2b && $past(clk_en) && $stable(timers) |=>
      reg_rdata == {$past(reg_code), 1'b0, $past(timers)};
  endproperty
  property p_gain;
    rd_ok && reg_addr == 8'h2d && $past(clk_en) && !$past(set_default_cmd)
      && $stable(am_gain_src) && $stable(pm_gain_src) |=>
      reg_rdata == {sat($past(am_gain_src)), sat($past(pm_gain_src))};
  endproperty
  property p_clear;
    s_clear |=> reg_rdata == 8'h00;
  endproperty
  property p_logic;
    clk_en && msg_start ##1 clk_en |=> strength_for_logic == 4'h0;
  endproperty
  property p_ext;
    s_ext_wr |=> reg_code == $past(reg_wdata[6:3], 2);
  endproperty
  property p_used;
    reg_code_used == (reg_code >= 4'h5);
  endproperty
  property p_unmapped;
    rd_ok && (reg_addr < 8'h2a || reg_addr > 8'h2d) |=> reg_rdata == 8'h00;
  endproperty
  property p_stand;
    !rd_ok |=> $stable(reg_rdata);
  endproperty

  a_reg_rd: assert property (p_reg_rd)
    else $error("regulator readback mismatch");
  a_gain: assert property (p_gain)
    else $error("gain cut readback mismatch");
  a_clear: assert property (p_clear)
    else $error("strength peak not cleared");
  a_logic: assert property (p_logic)
    else $error("selected strength not cleared");
  a_ext: assert property (p_ext)
    else $error("external code not in effect");
  a_used: assert property (p_used)
    else $error("code used flag wrong");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_stand: assert property (p_stand)
    else $error("read data changed without read");
endmodule

bind rsrb_top rsrb_top_chk u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timers(timers),
  .am_meas(am_meas), .pm_meas(pm_meas), .am_gain_src(am_gain_src),
  .pm_gain_src(pm_gain_src), .msg_start(msg_start),
  .clr_strength_cmd(clr_strength_cmd), .set_default_cmd(set_default_cmd),
  .strength_for_logic(strength_for_logic), .reg_code(reg_code),
  .reg_code_used(reg_code_used)
);
